// >>> core/clk_switch_pkg.sv
// Constants, encodings and timing counts for the clock switch and tune block.
// Assumes a single 250 MHz system clock and a synchronous active-low reset.
package clk_switch_pkg;
  // Field widths
  localparam int SRC_W = 3;
  localparam int DIV_W = 4;
  localparam int TRIM_W = 6;
  localparam int NUM_OSC = 8;
  // Source encodings
  localparam logic [SRC_W-1:0] SRC_HFINT = 3'h6;
  localparam logic [SRC_W-1:0] SRC_LFINT = 3'h5;
  localparam logic [SRC_W-1:0] SRC_SEC = 3'h4;
  localparam logic [SRC_W-1:0] SRC_EXT = 3'h7;
  // Reset values and trim limits
  localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;
  localparam logic [TRIM_W-1:0] TRIM_MAX = 6'h1f;
  localparam logic [TRIM_W-1:0] TRIM_MIN = 6'h20;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  // Low-frequency oscillator timing
  localparam int CLK_HZ = 250000000;
  localparam int LF_HZ = 31000;
  localparam int LF_HALF_CYCLES = CLK_HZ / (2 * LF_HZ);
  // Trim slew: one step per this many cycles
  localparam int TRIM_STEP_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TRIM_STEP_CYCLES = TRIM_STEP_NS / CLK_PERIOD_NS;
  // Switch state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HELD = 3'b100
  } sw_state_t;
endpackage : clk_switch_pkg

// >>> core/lf_osc_tick.sv
// Divider producing the low-frequency oscillator tick and its square wave.
// Assumes the system clock rate given in the package.
`timescale 1ns/1ps
module lf_osc_tick #(
  parameter int HALF = clk_switch_pkg::LF_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic tick_o,
  output logic level_o
);
  import clk_switch_pkg::*;
  // Refuse half periods the 16-bit counter cannot count
  if (HALF < 2 || HALF > 65536) begin : g_half_check
    $error("HALF out of range");
  end
  // Half-period counter
  logic [15:0] cnt;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
      level_o <= 1'b0;
    end else if (!run_i) begin
      cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt == 16'(HALF - 1)) begin
      cnt <= 16'h0000;
      tick_o <= ~level_o;
      level_o <= ~level_o;
    end else begin
      cnt <= cnt + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : lf_osc_tick

// >>> core/hf_trim_slew.sv
// Gradual slew of the applied high-frequency trim toward its target.
// Assumes the target is a signed six-bit value held by the caller.
`timescale 1ns/1ps
module hf_trim_slew #(
  parameter int STEP = clk_switch_pkg::TRIM_STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [clk_switch_pkg::TRIM_W-1:0] target_i,
  output logic [clk_switch_pkg::TRIM_W-1:0] applied_o
);
  import clk_switch_pkg::*;
  // Refuse step spacings the 16-bit counter cannot count
  if (STEP < 1 || STEP > 65536) begin : g_step_check
    $error("STEP out of range");
  end
  // Step pacing counter
  logic [15:0] cnt;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= 16'h0000;
      applied_o <= TRIM_RESET;
    end else if (cnt == 16'(STEP - 1)) begin
      cnt <= 16'h0000;
      if ($signed(applied_o) < $signed(target_i)) begin
        applied_o <= applied_o + 6'h01;
      end else if ($signed(applied_o) > $signed(target_i)) begin
        applied_o <= applied_o - 6'h01;
      end
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : hf_trim_slew

// >>> core/clk_switch_ctrl.sv
// Top of the system clock source selector with trim and oscillator status.
// Assumes oscillator ready inputs are synchronous to CLOCK_I.
`timescale 1ns/1ps
module clk_switch_ctrl (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  // Reset-time source configuration
  input wire logic [clk_switch_pkg::SRC_W-1:0] RESET_SOURCE_CONFIG_I,
  // Software request
  input wire logic REQ_WR_I,
  input wire logic [clk_switch_pkg::SRC_W-1:0] NEW_SOURCE_SELECT_I,
  input wire logic [clk_switch_pkg::DIV_W-1:0] NEW_DIVIDER_SELECT_I,
  input wire logic SWITCH_HOLD_I,
  input wire logic CPU_REDUCED_RATE_I,
  input wire logic SLEEP_REQ_I,
  // Trim write
  input wire logic TRIM_WR_I,
  input wire logic [clk_switch_pkg::TRIM_W-1:0] TRIM_I,
  // Interrupt flag control
  input wire logic SWITCH_IRQ_ENABLE_I,
  input wire logic IRQ_FLAG_CLR_I,
  // Manual enables and raw oscillator ready
  input wire logic [clk_switch_pkg::NUM_OSC-1:0] OSC_MANUAL_ENABLES_I,
  input wire logic [clk_switch_pkg::NUM_OSC-1:0] OSC_READY_RAW_I,
  // Outputs
  output logic [clk_switch_pkg::NUM_OSC-1:0] OSC_RUN_O,
  output logic [clk_switch_pkg::NUM_OSC-1:0] OSC_READY_FLAGS_O,
  output logic [clk_switch_pkg::SRC_W-1:0] CURRENT_SOURCE_FIELD_O,
  output logic [clk_switch_pkg::DIV_W-1:0] CURRENT_DIVIDER_O,
  output logic [clk_switch_pkg::SRC_W-1:0] REQ_SOURCE_O,
  output logic [clk_switch_pkg::DIV_W-1:0] REQ_DIVIDER_O,
  output logic NEW_SOURCE_READY_O,
  output logic OSC_READY_STATUS_O,
  output logic SWITCH_IRQ_FLAG_O,
  output logic IRQ_REQ_O,
  output logic SWITCH_DONE_O,
  output logic SLEEP_ENTER_O,
  output logic [clk_switch_pkg::TRIM_W-1:0] HF_TRIM_VALUE_O,
  output logic [clk_switch_pkg::TRIM_W-1:0] HF_TRIM_APPLIED_O,
  output logic LF_TICK_O,
  output logic LF_CLK_O
);
  import clk_switch_pkg::*;

  // Bit select of one oscillator from its source code
  function automatic logic [NUM_OSC-1:0] src_onehot(input logic [SRC_W-1:0] s);
    src_onehot = '0;
    src_onehot[s] = 1'b1;
  endfunction : src_onehot

  sw_state_t state; // Switch sequencer
  logic [TRIM_W-1:0] trim_value; // Software trim target
  logic [TRIM_W-1:0] trim_applied; // Slewed trim
  logic lf_tick; // Divider tick
  logic lf_level; // Divider square wave
  logic lf_run; // Low-frequency oscillator running
  logic ready_new; // Requested source ready now
  logic switch_now; // Switch completes this cycle
  logic set_flag; // Ready event this cycle
  logic boot; // First cycle after reset release
  logic [NUM_OSC-1:0] run_vec; // Oscillator enables

  // Requested source ready, or same source reused
  // immediate ready
  assign ready_new = (REQ_SOURCE_O == CURRENT_SOURCE_FIELD_O) ||
                     OSC_READY_RAW_I[REQ_SOURCE_O];
  assign switch_now = (state != ST_IDLE) && ready_new && !SWITCH_HOLD_I && !REQ_WR_I;
  assign set_flag = (state == ST_WAIT) && ready_new && !REQ_WR_I;
  assign lf_run = run_vec[SRC_LFINT];
  // manual enables with current and requested
  assign run_vec = OSC_MANUAL_ENABLES_I | src_onehot(CURRENT_SOURCE_FIELD_O) |
                   src_onehot(REQ_SOURCE_O);

  // Low-frequency divider, independent of trim
  // no trim input
  lf_osc_tick u_lf (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .run_i(lf_run),
    .tick_o(lf_tick),
    .level_o(lf_level)
  );

  // Trim slewing toward target
  hf_trim_slew u_trim (
    .clk_i(CLOCK_I),
    .nrst_i(NRST_I),
    .target_i(trim_value),
    .applied_o(trim_applied)
  );

  // Trim register
  // trim reset zero
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      trim_value <= TRIM_RESET;
    end else if (TRIM_WR_I) begin
      trim_value <= TRIM_I;
    end
  end

  // Boot marker to capture the reset configuration after release
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  // Request fields; boot loads reset configuration
  // source and divider request
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      REQ_SOURCE_O <= SRC_HFINT;
      REQ_DIVIDER_O <= DIV_RESET;
    end else if (boot) begin
      REQ_SOURCE_O <= RESET_SOURCE_CONFIG_I;
      REQ_DIVIDER_O <= DIV_RESET;
    end else if (REQ_WR_I) begin
      REQ_SOURCE_O <= NEW_SOURCE_SELECT_I;
      REQ_DIVIDER_O <= NEW_DIVIDER_SELECT_I;
    end
  end

  // Switch sequencer
  // hold old clock while waiting
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      state <= ST_IDLE;
    end else if (REQ_WR_I) begin
      state <= ST_WAIT;
    end else begin
      unique case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_WAIT: begin
          if (switch_now) begin
            state <= ST_IDLE;
          end else if (ready_new) begin
            state <= ST_HELD;
          end
        end
        ST_HELD: begin
          // released by hold clear or cancel
          if (switch_now) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Current fields; switch takes effect on next edge even in reduced rate
  // current follows request
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      CURRENT_SOURCE_FIELD_O <= SRC_HFINT;
      CURRENT_DIVIDER_O <= DIV_RESET;
      SWITCH_DONE_O <= 1'b0;
    end else if (boot) begin
      CURRENT_SOURCE_FIELD_O <= RESET_SOURCE_CONFIG_I;
      CURRENT_DIVIDER_O <= DIV_RESET;
      SWITCH_DONE_O <= 1'b0;
    end else begin
      SWITCH_DONE_O <= switch_now;
      if (switch_now) begin
        CURRENT_SOURCE_FIELD_O <= REQ_SOURCE_O;
        CURRENT_DIVIDER_O <= REQ_DIVIDER_O;
      end
    end
  end

  // Ready status bits
  // ready status set
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      NEW_SOURCE_READY_O <= 1'b0;
      OSC_READY_STATUS_O <= 1'b0;
    end else begin
      NEW_SOURCE_READY_O <= (state != ST_IDLE) && ready_new && !REQ_WR_I;
      OSC_READY_STATUS_O <= OSC_READY_RAW_I[CURRENT_SOURCE_FIELD_O];
    end
  end

  // Sticky interrupt flag; set wins over clear
  // flag set
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      SWITCH_IRQ_FLAG_O <= 1'b0;
      IRQ_REQ_O <= 1'b0;
    end else begin
      if (set_flag) begin
        SWITCH_IRQ_FLAG_O <= 1'b1;
      end else if (IRQ_FLAG_CLR_I) begin
        SWITCH_IRQ_FLAG_O <= 1'b0;
      end
      IRQ_REQ_O <= SWITCH_IRQ_ENABLE_I && (set_flag || (SWITCH_IRQ_FLAG_O && !IRQ_FLAG_CLR_I));
    end
  end

  // Oscillator status, enables, sleep grant and registered trim view
  // ready flags
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      OSC_RUN_O <= '0;
      OSC_READY_FLAGS_O <= '0;
      SLEEP_ENTER_O <= 1'b0;
      HF_TRIM_VALUE_O <= TRIM_RESET;
      HF_TRIM_APPLIED_O <= TRIM_RESET;
      LF_TICK_O <= 1'b0;
      LF_CLK_O <= 1'b0;
    end else begin
      OSC_RUN_O <= run_vec;
      OSC_READY_FLAGS_O <= OSC_READY_RAW_I & run_vec;
      SLEEP_ENTER_O <= SLEEP_REQ_I;
      HF_TRIM_VALUE_O <= trim_value;
      HF_TRIM_APPLIED_O <= trim_applied;
      LF_TICK_O <= lf_tick;
      LF_CLK_O <= lf_level;
    end
  end

  // Flag follows ready event by one edge
  property p_flag_set;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    set_flag |=> SWITCH_IRQ_FLAG_O;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  // Interrupt only when enabled
  property p_irq_en;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    IRQ_REQ_O |-> $past(SWITCH_IRQ_ENABLE_I);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");

  // Enabled set raises request
  property p_irq_raise;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (set_flag && SWITCH_IRQ_ENABLE_I) |=> IRQ_REQ_O;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq missing");

  // Hold keeps current source
  property p_hold;
    @(posedge CLOCK_I) disable iff (!NRST_I || boot)
    SWITCH_HOLD_I |=> $stable(CURRENT_SOURCE_FIELD_O);
  endproperty
  a_hold: assert property (p_hold) else $error("switched under hold");

  // Completion copies request
  property p_done;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    switch_now |=> (CURRENT_SOURCE_FIELD_O == $past(REQ_SOURCE_O)) && SWITCH_DONE_O;
  endproperty
  a_done: assert property (p_done) else $error("current not updated");

  // Divider-only change completes next cycle
  property p_div_only;
    @(posedge CLOCK_I) disable iff (!NRST_I || boot)
    (REQ_WR_I && NEW_SOURCE_SELECT_I == CURRENT_SOURCE_FIELD_O && !SWITCH_HOLD_I)
      ##1 (!REQ_WR_I && !SWITCH_HOLD_I) |=> SWITCH_DONE_O;
  endproperty
  a_div_only: assert property (p_div_only) else $error("no immediate switch");

  // Old source stays while not ready
  property p_wait;
    @(posedge CLOCK_I) disable iff (!NRST_I || boot)
    (state == ST_WAIT && !ready_new) |=> $stable(CURRENT_SOURCE_FIELD_O);
  endproperty
  a_wait: assert property (p_wait) else $error("switched before ready");

  // Trim starts at zero after reset
  property p_trim_rst;
    @(posedge CLOCK_I) $rose(NRST_I) |-> HF_TRIM_VALUE_O == TRIM_RESET;
  endproperty
  a_trim_rst: assert property (p_trim_rst) else $error("trim reset");

  // Sleep granted even while pending
  property p_sleep;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    SLEEP_REQ_I |=> SLEEP_ENTER_O;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep blocked");

  // Reduced-rate mode never delays completion
  property p_cpu_reduced_rate;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (switch_now && CPU_REDUCED_RATE_I) |=>
      SWITCH_DONE_O && (CURRENT_DIVIDER_O == $past(REQ_DIVIDER_O));
  endproperty
  a_cpu_reduced_rate: assert property (p_cpu_reduced_rate) else $error("switch delayed in reduced rate");

  // Ready event sets the status bit
  property p_nsr;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    set_flag |=> NEW_SOURCE_READY_O;
  endproperty
  a_nsr: assert property (p_nsr) else $error("ready status not set");
endmodule : clk_switch_ctrl

// >>> bench/testbench.sv
// Self-checking bench for the clock switch and tune block.
// Assumes the block's ports as declared and a 250 MHz system clock.
`timescale 1ns/1ps
module testbench;
  import clk_switch_pkg::*;
  // Stimulus and observed signals
  logic clk, nrst, req_wr, hold, cpu_reduced_rate, sleep, trim_wr, irq_en, flag_clr;
  logic [2:0] new_src, cur_src_o, req_src_o, rst_cfg;
  logic [3:0] new_div, cur_div_o, req_div_o;
  logic [5:0] trim, trim_v, trim_a;
  logic [7:0] man_en, raw_rdy, osc_run, rdy_flags;
  logic nsr, osc_ready_status, flag_o, irq, done, sleep_en, lf_tick, lf_clk;
  // Scoreboard counters and scratch
  int n_errors = 0;
  int tests_run = 0;
  int d, n, i;
  logic [5:0] tv[$];

  clk_switch_ctrl u_clk_switch_ctrl (.CLOCK_I(clk), .NRST_I(nrst),
    .RESET_SOURCE_CONFIG_I(rst_cfg), .REQ_WR_I(req_wr), .NEW_SOURCE_SELECT_I(new_src),
    .NEW_DIVIDER_SELECT_I(new_div), .SWITCH_HOLD_I(hold), .CPU_REDUCED_RATE_I(cpu_reduced_rate),
    .SLEEP_REQ_I(sleep), .TRIM_WR_I(trim_wr), .TRIM_I(trim), .SWITCH_IRQ_ENABLE_I(irq_en),
    .IRQ_FLAG_CLR_I(flag_clr), .OSC_MANUAL_ENABLES_I(man_en), .OSC_READY_RAW_I(raw_rdy),
    .OSC_RUN_O(osc_run), .OSC_READY_FLAGS_O(rdy_flags), .CURRENT_SOURCE_FIELD_O(cur_src_o),
    .CURRENT_DIVIDER_O(cur_div_o), .REQ_SOURCE_O(req_src_o), .REQ_DIVIDER_O(req_div_o),
    .NEW_SOURCE_READY_O(nsr), .OSC_READY_STATUS_O(osc_ready_status), .SWITCH_IRQ_FLAG_O(flag_o),
    .IRQ_REQ_O(irq), .SWITCH_DONE_O(done), .SLEEP_ENTER_O(sleep_en),
    .HF_TRIM_VALUE_O(trim_v), .HF_TRIM_APPLIED_O(trim_a), .LF_TICK_O(lf_tick),
    .LF_CLK_O(lf_clk));

  // Free-running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Compare seen against expected
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // A bounded wait that ran out counts as a mismatch and closes the run
  task automatic limit_hit(input int cnt, input int lim);
    if (cnt >= lim) begin
      n_errors++;
      wrap_up;
    end
  endtask : limit_hit

  // One edge, inputs change 1 ns after it
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Pulse the request strobe for one edge
  task automatic req(input int s, input int dv);
    req_wr = 1'b1;
    new_src = s[2:0];
    new_div = dv[3:0];
    tick;
    req_wr = 1'b0;
  endtask : req

  // Clear the sticky flag
  task automatic clr;
    flag_clr = 1'b1;
    tick;
    flag_clr = 1'b0;
    check("flag_clr", flag_o, 0);
  endtask : clr

  // Bounded wait for completion, then model compare; lat below 0 means any
  task automatic finish_switch(input int s, input int dv, input int lat);
    int k;
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      tick;
      k++;
    end
    if (k == 40) begin
      n_errors++;
      wrap_up;
    end
    if (lat >= 0) check("latency", k, lat);
    check("cur_src", cur_src_o, s);
    check("cur_div", cur_div_o, dv);
    check("flag", flag_o, 1);
    check("irq", irq, irq_en);
    tick;
    check("done_pulse", done, 0);
  endtask : finish_switch

  // Bounded wait until the applied trim reaches the target
  task automatic trim_to(input logic [5:0] v);
    int k;
    int s;
    // Model: signed distance from the last target, one step per pacing period
    s = $signed(v) - $signed(trim);
    if (s < 0) s = -s;
    trim = v;
    trim_wr = 1'b1;
    tick;
    trim_wr = 1'b0;
    tick;
    check("trim_value", trim_v, v);
    check("trim_not_instant", (trim_a == v), 0);
    k = 0;
    while (trim_a !== v && k < 7000) begin
      tick;
      k++;
    end
    limit_hit(k, 7000);
    check("trim_settled", trim_a, v);
    check("trim_steps", (k > (s - 1) * TRIM_STEP_CYCLES) && (k <= s * TRIM_STEP_CYCLES), 1);
  endtask : trim_to

  initial begin
    void'($urandom(32'h83e44ee6));
    {req_wr, hold, cpu_reduced_rate, sleep, trim_wr, irq_en, flag_clr} = '0;
    new_src = SRC_HFINT;
    new_div = DIV_RESET;
    trim = TRIM_RESET;
    man_en = 8'h00;
    raw_rdy = 8'h60;
    rst_cfg = SRC_HFINT;
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    tick;
    check("rst_src", cur_src_o, SRC_HFINT);
    check("rst_trim", trim_v, 0);
    tick;
    // Divider-only changes complete at once, with and without reduced rate
    for (i = 0; i < 3; i++) begin
      irq_en = 1'($urandom);
      cpu_reduced_rate = i[0];
      d = $urandom_range(15);
      clr;
      req(SRC_HFINT, d);
      check("req_div", req_div_o, d);
      check("req_src", req_src_o, SRC_HFINT);
      finish_switch(SRC_HFINT, d, 1);
    end
    // New source not yet ready: old clock stays, sleep still allowed
    irq_en = 1'b1;
    sleep = 1'b1;
    clr;
    req(SRC_EXT, 3);
    repeat (10) tick;
    check("wait_done", done, 0);
    check("wait_src", cur_src_o, SRC_HFINT);
    check("sleep", sleep_en, 1);
    check("run_req", osc_run[7], 1);
    sleep = 1'b0;
    raw_rdy[7] = 1'b1;
    finish_switch(SRC_EXT, 3, -1);
    check("osc_ready_status", osc_ready_status, 1);
    // Held switch: ready reported, clock unchanged until release
    hold = 1'b1;
    clr;
    req(SRC_HFINT, 0);
    repeat (2) tick;
    check("held_nsr", nsr, 1);
    check("held_flag", flag_o, 1);
    repeat (4) tick;
    check("held_done", done, 0);
    check("held_src", cur_src_o, SRC_EXT);
    hold = 1'b0;
    finish_switch(SRC_HFINT, 0, -1);
    // Abandon a pending switch by asking for the current source
    clr;
    req(SRC_SEC, 0);
    repeat (4) tick;
    check("pend_src", cur_src_o, SRC_HFINT);
    req(SRC_HFINT, 5);
    finish_switch(SRC_HFINT, 5, 1);
    // Manual enable and per-oscillator ready
    man_en = 8'h10;
    raw_rdy[4] = 1'b1;
    repeat (3) tick;
    check("run", osc_run, 8'h50);
    check("ready_flags", rdy_flags, 8'h50);
    // Low-frequency source request enables it; period unaffected by trim
    clr;
    req(SRC_LFINT, 0);
    finish_switch(SRC_LFINT, 0, -1);
    check("lf_run", osc_run[5], 1);
    trim = TRIM_MAX;
    trim_wr = 1'b1;
    tick;
    trim_wr = 1'b0;
    n = 0;
    while (lf_tick !== 1'b1 && n < 9000) begin
      tick;
      n++;
    end
    limit_hit(n, 9000);
    n = 0;
    do begin
      tick;
      n++;
    end while (lf_tick !== 1'b1 && n < 9000);
    limit_hit(n, 9000);
    check("lf_period", n, 2 * LF_HALF_CYCLES);
    check("lf_clk", lf_clk, 1);
    // Targets always differ from the settled one, so a slew is seen each time
    tv = '{TRIM_MIN, TRIM_MAX, 6'($urandom_range(29))};
    foreach (tv[j]) trim_to(tv[j]);
    // Reset again in mid-run with the low-frequency source as reset choice
    rst_cfg = SRC_LFINT;
    nrst = 1'b0;
    repeat (2) tick;
    nrst = 1'b1;
    tick;
    check("rst2_src", cur_src_o, SRC_LFINT);
    check("rst2_trim", trim_v, 0);
    check("rst2_flag", flag_o, 0);
    tick;
    check("rst2_lf_run", osc_run[5], 1);
    wrap_up;
  end
endmodule : testbench
